/* dv/ocs_analog_model.sv */
// Behavioural comparator and threshold DAC at the far side
`timescale 1ns/1ps
`default_nettype none
module ocs_analog_model (
  // Clock
  input wire logic aclk,
  // Reference from the block
  input wire logic [9:0] dac_code,
  input wire logic dac_channel_two,
  input wire logic analog_power_up,
  // Sensed currents as codes
  input wire logic [9:0] level_one,
  input wire logic [9:0] level_two,
  // Comparator outputs
  output logic sense_input_one,
  output logic sense_input_two
);
  initial begin
    sense_input_one = 1'b0;
    sense_input_two = 1'b0;
  end
  // Unselected channel keeps its last decision
  always @(posedge aclk) begin
    if (!analog_power_up) begin
      sense_input_one <= 1'b0;
      sense_input_two <= 1'b0;
    end else if (dac_channel_two) begin
      sense_input_two <= (level_two > dac_code);
    end else begin
      sense_input_one <= (level_one > dac_code);
    end
  end
endmodule // ocs_analog_model
`default_nettype wire

/* dv/tb_top.sv */
// Register level bench for the overcurrent compare status block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ocs_pkg::*;
  logic aclk, aresetn;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic sense_input_one, sense_input_two, dac_channel_two, analog_power_up;
  logic comparator_interrupt;
  logic [9:0] dac_code, level_one, level_two;
  int failures, compares, n;
  logic [1:0] exp_bresp;

  ocs_compare_status DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .sense_input_one, .sense_input_two, .dac_code,
    .dac_channel_two, .analog_power_up, .comparator_interrupt);
  ocs_analog_model far_side (.aclk, .dac_code, .dac_channel_two, .analog_power_up,
    .level_one, .level_two, .sense_input_one, .sense_input_two);

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // ==========================================
  // Tasks
  task automatic conclude();
    if (failures == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stall();
    failures++;
    conclude();
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    int k;
    @(posedge aclk);
    s_axi_awaddr <= {2'h0, idx, 2'h0};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    k = 0;
    do begin
      @(posedge aclk);
      k++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (k > 100) stall();
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, exp_bresp}, {30'h0, s_axi_bresp});
  endtask
  task automatic rd(input logic [7:0] idx);
    int k;
    @(posedge aclk);
    s_axi_araddr <= {2'h0, idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    k = 0;
    do begin
      @(posedge aclk);
      k++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (k > 100) stall();
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    rd_data = s_axi_rdata;
  endtask
  task automatic rdc(input string what, input logic [7:0] idx, input logic [31:0] exp);
    rd(idx);
    chk(what, exp, rd_data);
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge aclk);
  endtask
  task automatic chk_irq(input logic exp);
    idle(3);
    chk("irq", {31'h0, exp}, {31'h0, comparator_interrupt});
  endtask
  task automatic wait_lvl(input logic v);
    while (dac_channel_two !== v) begin
      @(posedge aclk);
      n++;
      if (n > 9000) stall();
    end
  endtask

  // ==========================================
  // Sequence
  initial begin
    failures = 0;
    compares = 0;
    exp_bresp = resp_okay;
    aresetn = 1'b0;
    s_axi_awaddr = 12'h0;
    s_axi_araddr = 12'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    level_one = 10'h0;
    level_two = 10'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rdc("ctl", idx_ctl, 32'h0);
    rdc("status", idx_chg_sts, 32'h0);
    rdc("enable", idx_irq_en, 32'h0);
    rdc("thr1", idx_thr1, 32'h0);
    rdc("debounce", idx_debounce, {24'h0, debounce_rst});
    rdc("unmapped", 8'h90, 32'h0);
    chk("rresp", {30'h0, resp_slverr}, {30'h0, s_axi_rresp});
    // Unmapped write is refused with an error response
    exp_bresp = resp_slverr;
    wr(8'h90, 32'hff);
    exp_bresp = resp_okay;
    wr(idx_debounce, 32'h0);
    rdc("debounce", idx_debounce, 32'h0);
    wr(idx_ctl, {30'h0, mode_ch1});
    chk("power", 32'h1, {31'h0, analog_power_up});
    wr(idx_thr1, 32'h40);
    chk("dac", 32'h0, {22'h0, dac_code});
    rdc("thr1", idx_thr1, 32'h0);
    wr(idx_thr1_hi, 32'h1);
    chk("dac", 32'h140, {22'h0, dac_code});
    rdc("thr1 hi", idx_thr1_hi, 32'h1);
    level_one <= 10'h200;
    idle(4 * sample_cycles);
    rdc("match", idx_match, 32'h1);
    rdc("status", idx_chg_sts, 32'h41);
    chk_irq(1'b0);
    wr(idx_irq_en, 32'h40);
    chk_irq(1'b1);
    wr(idx_chg_sts, 32'h40);
    rdc("status", idx_chg_sts, 32'h01);
    chk_irq(1'b0);
    wr(idx_chg_sts, 32'h0);
    rdc("status", idx_chg_sts, 32'h01);
    wr(idx_irq_en, 32'h01);
    chk_irq(1'b1);
    wr(idx_chg_sts, 32'h01);
    chk_irq(1'b0);
    level_one <= 10'h0;
    idle(4 * sample_cycles);
    rdc("status", idx_chg_sts, 32'h01);
    rdc("match", idx_match, 32'h0);
    chk_irq(1'b1);
    wr(idx_chg_sts, 32'hc3);
    wr(idx_thr2, 32'h80);
    wr(idx_thr2_hi, 32'h0);
    level_two <= 10'h200;
    wr(idx_ctl, {30'h0, mode_both});
    n = 0;
    wait_lvl(1'b0);
    wait_lvl(1'b1);
    chk("dac", 32'h80, {22'h0, dac_code});
    n = 0;
    wait_lvl(1'b0);
    wait_lvl(1'b1);
    chk("period", 2 * sample_cycles, n);
    idle(6 * sample_cycles);
    rdc("match", idx_match, 32'h2);
    rdc("status", idx_chg_sts, 32'h82);
    // Channel two flags against their own enables
    chk_irq(1'b0);
    wr(idx_irq_en, 32'h02);
    chk_irq(1'b1);
    wr(idx_irq_en, 32'h80);
    chk_irq(1'b1);
    wr(idx_irq_en, 32'h00);
    chk_irq(1'b0);
    wr(idx_ctl, {30'h0, mode_ch2});
    idle(3);
    chk("chan2", 32'h1, {31'h0, dac_channel_two});
    wr(idx_ctl, {30'h0, mode_off});
    idle(10);
    rdc("match", idx_match, 32'h0);
    chk("power", 32'h0, {31'h0, analog_power_up});
    // Reset in mid-run restores the defaults
    aresetn <= 1'b0;
    idle(3);
    aresetn <= 1'b1;
    rdc("debounce", idx_debounce, {24'h0, debounce_rst});
    rdc("status", idx_chg_sts, 32'h0);
    conclude();
  end
endmodule // tb_top
`default_nettype wire

/* rtl/ocs_compare_status.sv */
// Overcurrent compare status, enables, thresholds and debounce
`timescale 1ns/1ps
`default_nettype none
module ocs_compare_status (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Analog comparator and DAC
  input wire logic sense_input_one,
  input wire logic sense_input_two,
  output logic [9:0] dac_code,
  output logic dac_channel_two,
  output logic analog_power_up,
  // Interrupt
  output logic comparator_interrupt
);
  import ocs_pkg::*;

  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [11:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [1:0] comparator_sampling_control;
    logic [7:0] chg_sts;
    logic [7:0] irq_en;
    logic [9:0] thr1;
    logic [9:0] thr2;
    logic [7:0] thr1_lo;
    logic [7:0] thr2_lo;
    logic [7:0] debounce;
    logic [1:0] prev_match;
    logic [1:0] first_seen;
    logic [1:0] vld_pending;
    logic [11:0] div;
    logic phase;
    logic irq;
    logic [1:0] s1_sync;
    logic [1:0] s2_sync;
  } top_s;

  top_s st_r;
  top_s st_nxt;

  logic [1:0] debounced_match_bits;
  logic debouncer_running;
  logic tick;
  ocs_debounce_if dbi1 ();
  ocs_debounce_if dbi2 ();

  // ==========================================
  // Sample timing
  // ==========================================
  assign tick = (st_r.div == 12'(sample_cycles - 1));
  assign debouncer_running = (st_r.comparator_sampling_control != mode_off);

  // Each tick samples one channel; alternate mode halves each rate
  assign dbi1.sample_tick = tick && (st_r.comparator_sampling_control == mode_ch1 ||
    (st_r.comparator_sampling_control == mode_both && !st_r.phase));
  assign dbi2.sample_tick = tick && (st_r.comparator_sampling_control == mode_ch2 ||
    (st_r.comparator_sampling_control == mode_both && st_r.phase));
  assign dbi1.enable = st_r.comparator_sampling_control[0];
  assign dbi2.enable = st_r.comparator_sampling_control[1];
  assign dbi1.raw = st_r.s1_sync[1];
  assign dbi2.raw = st_r.s2_sync[1];
  assign dbi1.period = st_r.debounce;
  assign dbi2.period = st_r.debounce;
  assign debounced_match_bits = {dbi2.match, dbi1.match};

  ocs_debounce u_db1 (
    .aclk(aclk),
    .aresetn(aresetn),
    .dbi(dbi1.chan)
  );
  ocs_debounce u_db2 (
    .aclk(aclk),
    .aresetn(aresetn),
    .dbi(dbi2.chan)
  );

  // ==========================================
  // Next state
  // ==========================================
  logic wr_fire;
  logic [7:0] widx;
  logic [7:0] ridx;
  logic [7:0] wb;
  logic [1:0] chg_ev;
  logic [1:0] vld_ev;
  logic [7:0] set_bits;

  assign wr_fire = st_r.aw_got && st_r.w_got && !st_r.bvalid;
  assign widx = st_r.awaddr[9:2];
  assign ridx = s_axi_araddr[9:2];
  assign wb = st_r.wdata[7:0];
  assign chg_ev = debounced_match_bits ^ st_r.prev_match;
  // First sample taken after a channel's first enable since reset makes the match valid
  assign vld_ev = st_r.vld_pending & {dbi2.sample_tick, dbi1.sample_tick};
  assign set_bits = {vld_ev[1], vld_ev[0], 4'h0, chg_ev[1], chg_ev[0]};

  always_comb begin
    st_nxt = st_r;
    st_nxt.s1_sync = {st_r.s1_sync[0], sense_input_one};
    st_nxt.s2_sync = {st_r.s2_sync[0], sense_input_two};
    st_nxt.prev_match = debounced_match_bits;
    if (!debouncer_running || tick) begin
      st_nxt.div = 12'h000;
    end else begin
      st_nxt.div = st_r.div + 12'h001;
    end
    if (tick) begin
      st_nxt.phase = ~st_r.phase;
    end
    // Arm valid flag on first enable of each channel
    for (int i = 0; i < 2; i++) begin
      if (st_r.comparator_sampling_control[i] && !st_r.first_seen[i]) begin
        st_nxt.first_seen[i] = 1'b1;
        st_nxt.vld_pending[i] = 1'b1;
      end else if (vld_ev[i]) begin
        st_nxt.vld_pending[i] = 1'b0;
      end
    end
    // Write channel
    if (s_axi_awvalid && !st_r.aw_got) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_r.w_got) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
    end
    st_nxt.chg_sts = st_r.chg_sts;
    if (wr_fire) begin
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = resp_okay;
      if (st_r.awaddr[11:10] != 2'b00 || st_r.awaddr[1:0] != 2'b00) begin
        st_nxt.bresp = resp_slverr;
      end else if (st_r.wstrb[0]) begin
        case (widx)
          idx_ctl: st_nxt.comparator_sampling_control = wb[1:0];
          idx_chg_sts: st_nxt.chg_sts = st_r.chg_sts & ~(wb & sts_mask);
          idx_irq_en: st_nxt.irq_en = wb & sts_mask;
          idx_thr1: st_nxt.thr1_lo = wb;
          idx_thr1_hi: st_nxt.thr1 = {wb[1:0], st_r.thr1_lo};
          idx_thr2: st_nxt.thr2_lo = wb;
          idx_thr2_hi: st_nxt.thr2 = {wb[1:0], st_r.thr2_lo};
          idx_debounce: st_nxt.debounce = wb;
          idx_match: st_nxt.bresp = resp_okay;
          default: st_nxt.bresp = resp_slverr;
        endcase
      end
    end
    // Set wins over a clear in the same cycle
    st_nxt.chg_sts = st_nxt.chg_sts | set_bits;
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
    end
    // Read channel
    if (s_axi_arvalid && !st_r.rvalid) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = resp_okay;
      st_nxt.rdata = 32'h0000_0000;
      if (s_axi_araddr[11:10] != 2'b00 || s_axi_araddr[1:0] != 2'b00) begin
        st_nxt.rresp = resp_slverr;
      end else begin
        case (ridx)
          idx_ctl: st_nxt.rdata = {24'h0, debouncer_running, 5'h0,
            st_r.comparator_sampling_control};
          idx_match: st_nxt.rdata = {30'h0, debounced_match_bits};
          idx_chg_sts: st_nxt.rdata = {24'h0, st_r.chg_sts};
          idx_irq_en: st_nxt.rdata = {24'h0, st_r.irq_en};
          idx_thr1: st_nxt.rdata = {24'h0, st_r.thr1[7:0]};
          idx_thr1_hi: st_nxt.rdata = {30'h0, st_r.thr1[9:8]};
          idx_thr2: st_nxt.rdata = {24'h0, st_r.thr2[7:0]};
          idx_thr2_hi: st_nxt.rdata = {30'h0, st_r.thr2[9:8]};
          idx_debounce: st_nxt.rdata = {24'h0, st_r.debounce};
          default: st_nxt.rresp = resp_slverr;
        endcase
      end
    end else if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    st_nxt.irq = |(st_nxt.chg_sts & st_nxt.irq_en);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
      st_r.debounce <= debounce_rst;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================
  // Outputs
  // ==========================================
  assign s_axi_awready = !st_r.aw_got;
  assign s_axi_wready = !st_r.w_got;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = !st_r.rvalid;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign comparator_interrupt = st_r.irq;
  assign analog_power_up = debouncer_running;
  // DAC code in steps of about 2.5V/1024
  assign dac_channel_two = (st_r.comparator_sampling_control == mode_ch2) ||
    (st_r.comparator_sampling_control == mode_both && st_r.phase);
  assign dac_code = dac_channel_two ? st_r.thr2 : st_r.thr1;

  // ==========================================
  // Checks
  // ==========================================
  property p_chg_set;
    @(posedge aclk) disable iff (!aresetn)
      $changed(debounced_match_bits[0]) |=> st_r.chg_sts[chg1_bit];
  endproperty
  a_chg_set: assert property (p_chg_set) else $error("change flag not set");

  property p_irq;
    @(posedge aclk) disable iff (!aresetn)
      (|(st_r.chg_sts & st_r.irq_en)) == comparator_interrupt;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt mismatch");

  property p_irq_masked;
    @(posedge aclk) disable iff (!aresetn)
      (st_r.irq_en == 8'h00) |-> !comparator_interrupt;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("masked interrupt");

  property p_chg_mask;
    @(posedge aclk) disable iff (!aresetn)
      (st_r.chg_sts[chg2_bit] && st_r.irq_en[chg2_bit]) |-> comparator_interrupt;
  endproperty
  a_chg_mask: assert property (p_chg_mask) else $error("change irq missing");

  property p_vld;
    @(posedge aclk) disable iff (!aresetn)
      vld_ev[0] |=> st_r.chg_sts[vld1_bit];
  endproperty
  a_vld: assert property (p_vld) else $error("valid flag not set");

  property p_lo_only;
    @(posedge aclk) disable iff (!aresetn)
      (wr_fire && widx == idx_thr1 && st_r.awaddr[11:10] == 2'b00) |=> $stable(st_r.thr1);
  endproperty
  a_lo_only: assert property (p_lo_only) else $error("threshold moved on low byte");

  property p_w0_keep;
    @(posedge aclk) disable iff (!aresetn)
      (wr_fire && widx == idx_chg_sts && st_r.wstrb[0] && wb == 8'h00 &&
       st_r.awaddr[11:10] == 2'b00 && st_r.awaddr[1:0] == 2'b00)
      |=> (st_r.chg_sts == ($past(st_r.chg_sts) | $past(set_bits)));
  endproperty
  a_w0_keep: assert property (p_w0_keep) else $error("zero write changed flags");

  property p_tick;
    @(posedge aclk) disable iff (!aresetn)
      dbi1.sample_tick |-> st_r.div == 12'(sample_cycles - 1);
  endproperty
  a_tick: assert property (p_tick) else $error("sample period wrong");

  property p_off;
    @(posedge aclk) disable iff (!aresetn)
      (st_r.comparator_sampling_control == mode_off) |=> !debounced_match_bits[1];
  endproperty
  a_off: assert property (p_off) else $error("match set while off");
endmodule // ocs_compare_status
`default_nettype wire

/* rtl/ocs_debounce.sv */
// One channel debouncer for a sense comparator output
`timescale 1ns/1ps
`default_nettype none
module ocs_debounce (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Channel link
  ocs_debounce_if.chan dbi
);
  import ocs_pkg::*;

  typedef struct packed {
    logic match;
    logic cand;
    logic [7:0] cnt;
  } db_s;

  db_s st_r;
  db_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (!dbi.enable) begin
      st_nxt.match = 1'b0;
      st_nxt.cand = 1'b0;
      st_nxt.cnt = 8'h00;
    end else if (dbi.sample_tick) begin
      // Value must stay put for period+1 more ticks after it is first seen before it is taken
      if (dbi.raw != st_r.cand) begin
        st_nxt.cand = dbi.raw;
        st_nxt.cnt = 8'h00;
      end else if (dbi.raw != st_r.match) begin
        if (st_r.cnt >= dbi.period) begin
          st_nxt.match = dbi.raw;
          st_nxt.cnt = 8'h00;
        end else begin
          st_nxt.cnt = st_r.cnt + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dbi.match = st_r.match;

  property p_off_clear;
    @(posedge aclk) disable iff (!aresetn) !dbi.enable |=> !dbi.match;
  endproperty
  a_off_clear: assert property (p_off_clear) else $error("match not cleared when off");
endmodule // ocs_debounce
`default_nettype wire

/* rtl/ocs_debounce_if.sv */
// Carrier between the top and a channel debouncer
`timescale 1ns/1ps
`default_nettype none
interface ocs_debounce_if;
  logic sample_tick;
  logic enable;
  logic raw;
  logic [7:0] period;
  logic match;
  modport ctrl (output sample_tick, output enable, output raw, output period, input match);
  modport chan (input sample_tick, input enable, input raw, input period, output match);
endinterface
`default_nettype wire

/* rtl/ocs_pkg.sv */
// Constants for the overcurrent compare status block
package ocs_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] idx_ctl = 8'h80;
  localparam logic [7:0] idx_match = 8'h81;
  localparam logic [7:0] idx_chg_sts = 8'h82;
  localparam logic [7:0] idx_irq_en = 8'h83;
  localparam logic [7:0] idx_thr1 = 8'h84;
  localparam logic [7:0] idx_thr2 = 8'h86;
  localparam logic [7:0] idx_debounce = 8'h88;
  // Own indices for the upper threshold bits
  localparam logic [7:0] idx_thr1_hi = 8'h85;
  localparam logic [7:0] idx_thr2_hi = 8'h87;
  // Field positions
  localparam int vld2_bit = 7;
  localparam int vld1_bit = 6;
  localparam int chg2_bit = 1;
  localparam int chg1_bit = 0;
  localparam int active_bit = 7;
  // Debounce reset value and status bit mask
  localparam logic [7:0] debounce_rst = 8'h0f;
  localparam logic [7:0] sts_mask = 8'hc3;
  // Timing
  localparam int clk_hz = 20000000;
  localparam int sample_period_us = 100;
  localparam int sample_cycles = (clk_hz / 1000000) * sample_period_us;
  // Sampling modes
  localparam logic [1:0] mode_off = 2'b00;
  localparam logic [1:0] mode_ch1 = 2'b01;
  localparam logic [1:0] mode_ch2 = 2'b10;
  localparam logic [1:0] mode_both = 2'b11;
  // AXI responses
  localparam logic [1:0] resp_okay = 2'b00;
  localparam logic [1:0] resp_slverr = 2'b10;
endpackage
